// file: inc/mps_pkg.sv
// Shared types and constants of the three-by-three multi_port_switch.
// Assumes one system clock and a synchronous active-high reset.
package mps_pkg;

   // ==========================================================
   // Port counts and identities
   localparam int unsigned MST_CNT    = 3;
   localparam int unsigned SLV_CNT    = 3;
   localparam int unsigned ADDR_W     = 32;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned MST_INSTR  = 0;
   localparam int unsigned MST_DATA   = 1;
   localparam int unsigned MST_DMA    = 2;
   localparam int unsigned SLV_FLASH  = 0;
   localparam int unsigned SLV_SRAM   = 1;
   localparam int unsigned SLV_PERIPH = 2;

   // ==========================================================
   // Priority levels and default address map
   localparam logic [1:0] LVL_TOP = 2'h3;
   localparam logic [2:0][1:0] PRIO_DEF = {2'h0, 2'h1, 2'h2};
   localparam logic [2:0][31:0] BASE_DEF =
      {32'hC000_0000, 32'h4000_0000, 32'h0000_0000};
   localparam logic [2:0][31:0] MASK_DEF =
      {32'hF000_0000, 32'hF000_0000, 32'hF000_0000};

   // ==========================================================
   // Bus carriers
   typedef struct packed {
      logic              valid;
      logic              write;
      logic              elev;
      logic [31:0]       addr;
      logic [31:0]       wdata;
   } mps_mreq_t;

   typedef struct packed {
      logic              ready;
      logic              err;
      logic [31:0]       rdata;
   } mps_mresp_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [1:0]        mid;
      logic [31:0]       addr;
      logic [31:0]       wdata;
   } mps_sreq_t;

   typedef struct packed {
      logic              ready;
      logic [31:0]       rdata;
   } mps_sresp_t;

   typedef struct packed {
      logic [2:0]        gnt;
      logic [1:0]        last;
   } mps_arb_st_t;

endpackage

// file: rtl/mps_arb.sv
// Per-port arbiter: fixed level per master, elevation, round robin.
// Assumes requests come from logic on the same clock.
`timescale 1ns/10ps
module mps_arb
#(
   parameter logic [2:0][1:0] PRIO = mps_pkg::PRIO_DEF
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [2:0] i_req,
   input  wire logic [2:0] i_elev,
   output logic      [2:0] o_gnt
);

   mps_pkg::mps_arb_st_t st_r;
   mps_pkg::mps_arb_st_t st_nxt;
   logic [2:0][1:0]      lvl;
   logic [2:0]           top_mask;
   logic [1:0]           max_lvl;

   // ==========================================================
   // Effective levels
   always_comb
   begin
      max_lvl = 2'h0;
      for (int m = 0; m < 3; m++)
      begin
         lvl[m] = i_elev[m] ? mps_pkg::LVL_TOP : PRIO[m]; // [R7] [R8]
         if (i_req[m] && lvl[m] > max_lvl)
            max_lvl = lvl[m];
      end
      for (int m = 0; m < 3; m++)
         top_mask[m] = i_req[m] && (lvl[m] == max_lvl);
   end

   // ==========================================================
   // Grant selection
   always_comb
   begin
      logic       found;
      logic [1:0] best;
      logic [1:0] id;
      found  = 1'b0;
      best   = 2'h0;
      id     = 2'h0;
      st_nxt = st_r;
      if (!(|(st_r.gnt & i_req)))
      begin
         // The owner keeps the port until its request falls. [R5]
         st_nxt.gnt = 3'h0;
         for (int k = 1; k <= 3; k++)
         begin
            id = 2'((int'(st_r.last) + k) % 3);
            // Strictly greater wins, so ties go in rotation order. [R4] [R6]
            if (i_req[id] && (!found || lvl[id] > best))
            begin
               found = 1'b1;
               best  = lvl[id];
               st_nxt.gnt  = 3'h0;
               st_nxt.gnt[id] = 1'b1;
               st_nxt.last = id;
            end
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_gnt = st_r.gnt;

   // ==========================================================
   // Checks
   gnt_onehot_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
      $onehot0(st_r.gnt))
      else $error("Port granted to more than one master.");

   owner_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R5]
      (|(st_r.gnt & i_req)) |=> (st_r.gnt == $past(st_r.gnt)))
      else $error("Owner lost the port while still requesting.");

   top_level_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
      (!(|(st_r.gnt & i_req)) && (|i_req))
      |=> (|(st_r.gnt & $past(top_mask))))
      else $error("Free port not granted to a highest-level requester.");

   elev_wins_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
      (!(|(st_r.gnt & i_req)) && (|(i_req & i_elev)))
      |=> (|(st_r.gnt & $past(i_req & i_elev))))
      else $error("Elevated request lost to a non-elevated one.");

   rr_rotate_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
      (!(|(st_r.gnt & i_req)) && !$onehot0(top_mask)
         && top_mask[st_r.last])
      |=> (st_r.gnt != (3'h1 << $past(st_r.last))))
      else $error("Round robin regranted the last master on a tie.");

endmodule // mps_arb

// file: rtl/mps_switch.sv
// Three-master, three-slave multi_port_switch with per-port arbiters.
// Assumes masters hold a request until they see a ready pulse, and
// slaves answer a held request with a one-cycle ready pulse.
//
// Overview of operation
// R1: Three masters, three slaves, parallel connections.
// R2: Every port carries 32-bit address and data.
// R3: Two at once only with instruction fetch from flash.
// R4: Same-port contention goes to the higher priority.
// R5: Losers stall until the owner finishes.
// R6: Equal priorities rotate after the last granted master.
// R7: Priority is fixed per master port.
// R8: Masters may be elevated temporarily above their level.
// R9: Masters are instruction, data and dma_master.
// R10: Slaves are flash, SRAM, peripheral_bus_bridge; decoded.
// R11: Priorities and address windows are parameters.
`timescale 1ns/10ps
module mps_switch
#(
   parameter logic [2:0][1:0]  PRIO = mps_pkg::PRIO_DEF,  // [R11]
   parameter logic [2:0][31:0] BASE = mps_pkg::BASE_DEF,  // [R11]
   parameter logic [2:0][31:0] MASK = mps_pkg::MASK_DEF   // [R11]
)
(
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   input  wire mps_pkg::mps_mreq_t  [2:0]   i_mst_req,
   output mps_pkg::mps_mresp_t      [2:0]   o_mst_resp,
   output mps_pkg::mps_sreq_t       [2:0]   o_slv_req,
   input  wire mps_pkg::mps_sresp_t [2:0]   i_slv_resp
);

   typedef struct packed {
      mps_pkg::mps_sreq_t  [2:0] sreq;
      mps_pkg::mps_mresp_t [2:0] mresp;
   } mps_sw_st_t;

   mps_sw_st_t       st_r;
   mps_sw_st_t       st_nxt;
   logic [2:0][2:0]  dec;
   logic [2:0]       miss;
   logic [2:0]       lane_req;
   logic [2:0]       lane_gnt;
   logic [2:0][2:0]  port_req;
   logic [2:0][2:0]  port_elev;
   logic [2:0][2:0]  port_gnt;

   function automatic logic exempt(input int unsigned m, input int unsigned s);
      return (m == mps_pkg::MST_INSTR) && (s == mps_pkg::SLV_FLASH);
   endfunction

   // ==========================================================
   // Address decode and request gating
   always_comb
   begin
      logic hit;
      hit = 1'b0;
      for (int m = 0; m < 3; m++)
      begin
         hit    = 1'b0;
         dec[m] = 3'h0;
         for (int s = 0; s < 3; s++)
            if (!hit && ((i_mst_req[m].addr & MASK[s]) == BASE[s]))
            begin
               dec[m][s] = 1'b1; // [R10]
               hit = 1'b1;
            end
         miss[m] = i_mst_req[m].valid && !hit;
         // Only one transfer may run outside the fetch-from-flash path.
         lane_req[m] = i_mst_req[m].valid && hit
            && !(exempt(m, mps_pkg::SLV_FLASH)
                 && dec[m][mps_pkg::SLV_FLASH]); // [R3]
      end
      for (int s = 0; s < 3; s++)
         for (int m = 0; m < 3; m++)
         begin
            port_req[s][m] = i_mst_req[m].valid && dec[m][s]
               && (exempt(m, s) || lane_gnt[m]); // [R3]
            port_elev[s][m] = i_mst_req[m].elev; // [R8]
         end
   end

   // ==========================================================
   // Arbiters: one shared lane plus one per slave port
   mps_arb #(.PRIO(PRIO)) u_lane_arb
   (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_req  (lane_req),
      .i_elev (port_elev[0]),
      .o_gnt  (lane_gnt)
   );

   for (genvar s = 0; s < 3; s++)
   begin : g_port
      mps_arb #(.PRIO(PRIO)) u_arb // [R1] [R4]
      (
         .i_clk  (i_clk),
         .i_rst  (i_rst),
         .i_req  (port_req[s]),
         .i_elev (port_elev[s]),
         .o_gnt  (port_gnt[s])
      );
   end

   // ==========================================================
   // Routing and responses
   always_comb
   begin
      st_nxt = st_r;
      for (int m = 0; m < 3; m++)
         st_nxt.mresp[m] = '0;
      for (int s = 0; s < 3; s++)
      begin
         st_nxt.sreq[s] = '0;
         if (st_r.sreq[s].valid && i_slv_resp[s].ready)
         begin
            st_nxt.mresp[st_r.sreq[s].mid].ready = 1'b1; // [R1]
            st_nxt.mresp[st_r.sreq[s].mid].rdata = i_slv_resp[s].rdata;
         end
         for (int m = 0; m < 3; m++)
            // A request just answered is not sent again while the master
            // is still seeing its ready pulse.
            if (port_gnt[s][m] && port_req[s][m]
                && !(st_r.sreq[s].valid && i_slv_resp[s].ready)
                && !st_r.mresp[m].ready) // [R5]
            begin
               st_nxt.sreq[s].valid = 1'b1;
               st_nxt.sreq[s].write = i_mst_req[m].write;
               st_nxt.sreq[s].mid   = 2'(m); // [R9]
               st_nxt.sreq[s].addr  = i_mst_req[m].addr; // [R2]
               st_nxt.sreq[s].wdata = i_mst_req[m].wdata; // [R2]
            end
      end
      for (int m = 0; m < 3; m++)
         if (miss[m] && !st_r.mresp[m].ready)
         begin
            st_nxt.mresp[m].ready = 1'b1;
            st_nxt.mresp[m].err   = 1'b1;
         end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_slv_req  = st_r.sreq;
   assign o_mst_resp = st_r.mresp;

   // ==========================================================
   // Checks
   logic [1:0] side_cnt;
   always_comb
   begin
      side_cnt = 2'h0;
      for (int s = 0; s < 3; s++)
         if (st_r.sreq[s].valid
             && !exempt(int'(st_r.sreq[s].mid), s))
            side_cnt = side_cnt + 2'h1;
   end

   conc_limit_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
      side_cnt <= 2'h1)
      else $error("More than one transfer outside the fetch path.");

   for (genvar s = 0; s < 3; s++)
   begin : g_chk
      for (genvar m = 0; m < 3; m++)
      begin : g_mst
         // The master index is a constant here, so the past value is that
         // of the requesting master and not of the previous owner.
         mid_range_a: assert property (@(posedge i_clk) // [R9]
            disable iff (i_rst)
            (st_r.sreq[s].valid && st_r.sreq[s].mid == 2'(m))
            |-> $past(port_gnt[s][m] && i_mst_req[m].valid))
            else $error("Slave request names a master without the port.");

         addr_pass_a: assert property (@(posedge i_clk) // [R2]
            disable iff (i_rst)
            (st_r.sreq[s].valid && st_r.sreq[s].mid == 2'(m))
            |-> (st_r.sreq[s].addr == $past(i_mst_req[m].addr)
                 && st_r.sreq[s].wdata == $past(i_mst_req[m].wdata)))
            else $error("Address or data altered through the switch.");

         stall_hold_a: assert property (@(posedge i_clk) // [R5]
            disable iff (i_rst)
            (port_req[s][m] && !port_gnt[s][m])
            |=> !(st_r.sreq[s].valid && st_r.sreq[s].mid == 2'(m)))
            else $error("Master without the port reached the slave.");
      end

      decode_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
         st_r.sreq[s].valid
         |-> ((st_r.sreq[s].addr & MASK[s]) == BASE[s]))
         else $error("Request routed to the wrong slave.");

      resp_route_a: assert property (@(posedge i_clk) // [R1]
         disable iff (i_rst)
         (st_r.sreq[s].valid && i_slv_resp[s].ready)
         |=> o_mst_resp[$past(st_r.sreq[s].mid)].ready)
         else $error("Slave answer not returned to its master.");
   end

   // ==========================================================
   // Master-side checks
   for (genvar m = 0; m < 3; m++)
   begin : g_mchk
      miss_err_a: assert property (@(posedge i_clk) // [R10]
         disable iff (i_rst)
         (miss[m] && !st_r.mresp[m].ready)
         |=> (st_r.mresp[m].ready && st_r.mresp[m].err))
         else $error("Unmapped address not answered with an error.");

      err_only_miss_a: assert property (@(posedge i_clk) // [R10]
         disable iff (i_rst)
         st_r.mresp[m].err |-> $past(miss[m]))
         else $error("Error answer without an unmapped address.");
   end

endmodule // mps_switch

// file: tb/mps_slv_model.sv
// Behavioural model of the flash, SRAM and bridge slaves.
// Assumes the switch holds each request until the edge after ready.
`timescale 1ns/10ps
module mps_slv_model
(
   input  wire logic                       i_clk,
   input  wire logic                       i_rst,
   input  wire mps_pkg::mps_sreq_t  [2:0]  i_req,
   output mps_pkg::mps_sresp_t      [2:0]  o_resp = '0
);
   // ==========================================================
   // Storage and answer timing
   logic [31:0] mem [logic [31:0]];
   int          hold [3] = '{0, 1, 2};
   int          seed = 94;

   // Waits of 0 to 2 cycles give the switch prompt and slow answers.
   // Read data toggles while no answer is given, so it cannot be
   // mistaken for a held value.
   always @(posedge i_clk)
   begin
      for (int s = 0; s < 3; s++)
      begin
         o_resp[s].ready <= 1'b0;
         o_resp[s].rdata <= ~o_resp[s].rdata;
         if (!i_rst && i_req[s].valid && !o_resp[s].ready)
         begin
            if (hold[s] > 0)
               hold[s]--;
            else
            begin
               o_resp[s].ready <= 1'b1;
               if (i_req[s].write)
                  mem[i_req[s].addr] = i_req[s].wdata;
               o_resp[s].rdata <= mem.exists(i_req[s].addr) ?
                  mem[i_req[s].addr] : ~i_req[s].addr;
               hold[s] = {$random(seed)} % 3;
            end
         end
      end
   end
endmodule // mps_slv_model

// file: tb/testbench.sv
// Self-checking bench of the multi_port_switch.
// Assumes the slave model answers on the far side.
`timescale 1ns/10ps
module testbench;
   logic                        i_clk = 1'b0;
   logic                        i_rst = 1'b1;
   mps_pkg::mps_mreq_t  [2:0]   i_mst_req = '0;
   mps_pkg::mps_mresp_t [2:0]   o_mst_resp;
   mps_pkg::mps_sreq_t  [2:0]   o_slv_req;
   mps_pkg::mps_sresp_t [2:0]   i_slv_resp;
   int                          err_count = 0;
   int                          samples_checked = 0;
   int                          seed = 94;
   int                          peak = 0;
   int                          w;
   time                         done_t [3];
   logic [31:0]                 ref_mem [logic [31:0]];

   always #25 i_clk = ~i_clk;

   mps_switch dut
   (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_mst_req  (i_mst_req),
      .o_mst_resp (o_mst_resp),
      .o_slv_req  (o_slv_req),
      .i_slv_resp (i_slv_resp)
   );

   mps_slv_model slaves
   (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_req  (o_slv_req),
      .o_resp (i_slv_resp)
   );

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Ready is read at the edge before the switch updates it.
   task automatic xfer(input int m, input bit wr, input bit el,
                       input logic [31:0] adr, input bit bad);
      logic [31:0] wd;
      int          n;
      wd = $random(seed);
      n = 0;
      @(posedge i_clk);
      i_mst_req[m] <= '{1'b1, wr, el, adr, wd};
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_mst_resp[m].ready !== 1'b1 && n < 200);
      i_mst_req[m].valid <= 1'b0;
      i_mst_req[m].elev <= 1'b0;
      done_t[m] = $time;
      if (n >= 200)
         err_count++;
      check(o_mst_resp[m].err, bad);
      if (wr)
         ref_mem[adr] = wd;
      else if (!bad)
         check(o_mst_resp[m].rdata, ref_mem[adr]);
   endtask

   task automatic race(input int a, input bit ea, input int b,
                       input bit eb, output int win);
      fork
         xfer(a, 1, ea, mps_pkg::BASE_DEF[1] + 32'h100 + 4 * a, 0);
         xfer(b, 1, eb, mps_pkg::BASE_DEF[1] + 32'h100 + 4 * b, 0);
      join
      win = (done_t[a] < done_t[b]) ? a : b;
   endtask

   // ==========================================================
   // Lane watch: only instruction fetches from flash may overlap.
   always @(posedge i_clk)
   begin : lane_watch
      int lane;
      int busy;
      lane = 0;
      busy = 0;
      for (int s = 0; s < 3; s++)
      begin
         busy += o_slv_req[s].valid;
         lane += o_slv_req[s].valid &&
                 !(s == 0 && o_slv_req[s].mid == 2'h0);
      end
      if (busy > peak)
         peak = busy;
      if (busy > 0)
         check(lane > 1, 1'b0);
   end

   // ==========================================================
   // Scenarios
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int s = 0; s < 3; s++)
         for (int m = 0; m < 3; m++)
         begin
            xfer(m, 1, 0, mps_pkg::BASE_DEF[s] + 32'h10 * m, 0);
            xfer(m, 0, 0, mps_pkg::BASE_DEF[s] + 32'h10 * m, 0);
         end
      xfer(1, 0, 0, 32'h8000_0000, 1);
      $display("test address map done");
      for (int a = 0; a < 2; a++)
         for (int b = a + 1; b < 3; b++)
         begin
            race(a, 0, b, 0, w);
            check(w, a);
         end
      $display("test fixed priority done");
      race(0, 0, 2, 1, w);
      check(w, 2);
      race(0, 0, 2, 0, w);
      check(w, 0);
      $display("test elevation done");
      for (int k = 1; k < 3; k++)
      begin
         xfer(k, 1, 1, mps_pkg::BASE_DEF[1] + 32'h300, 0);
         race(1, 1, 2, 1, w);
         check(w, 3 - k);
      end
      $display("test round robin done");
      fork
         xfer(0, 0, 0, mps_pkg::BASE_DEF[0], 0);
         xfer(1, 1, 0, mps_pkg::BASE_DEF[1] + 32'h200, 0);
         xfer(2, 1, 0, mps_pkg::BASE_DEF[2] + 32'h200, 0);
      join
      check(done_t[1] < done_t[2], 1'b1);
      check(peak >= 2, 1'b1);
      $display("test concurrency done");
      complete_run();
   end

   // A hang anywhere ends the run through the same closing task.
   initial
   begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      $display("watchdog expired");
      complete_run();
   end
endmodule // testbench
